//--- rtl/rsw_consts.vh
// Purpose: Shared constants of the reset-source and watchdog block
// Assumes: 50 MHz system clock, APB with 32-bit data
// Notes: Offsets are byte addresses on the APB
`ifndef RSW_CONSTS_VH
`define RSW_CONSTS_VH

// Register byte offsets
`define RSW_ADDR_SRC 8'h00
`define RSW_ADDR_WDT 8'h04
`define RSW_ADDR_OSC 8'h08

// Reset cause flag positions
`define RSW_SRC_PIN_BIT 0
`define RSW_SRC_POR_BIT 1
`define RSW_SRC_CLK_BIT 2
`define RSW_SRC_CMP_BIT 5

// Oscillator control layout and reset value
`define RSW_OSC_CLKDET_BIT 7
`define RSW_OSC_EXT_BIT 3
`define RSW_OSC_FREQ_MSB 1
`define RSW_OSC_FREQ_LSB 0
`define RSW_OSC_RESET 8'h00
`define RSW_OSC_WMASK 8'h8B

// Watchdog keys, interval field and reset value
`define RSW_KEY_RESTART 8'hA5
`define RSW_KEY_DIS1 8'hDE
`define RSW_KEY_DIS2 8'hAD
`define RSW_KEY_LOCK 8'hFF
`define RSW_WDT_IVAL_RESET 3'h7
`define RSW_WDT_BASE_EXP 5'h06
`define RSW_WDT_KEY_WINDOW 3'h4

// Core-facing reset values
`define RSW_RESET_VECTOR 16'h0000
`define RSW_PORT_LATCH_RESET 8'hFF

// Timing
`define RSW_CLK_HZ 50000000
`define RSW_POR_TIMEOUT_MS 100
// 100 ms at 50 MHz, sized to the 23-bit timeout counter
`define RSW_POR_CYCLES 23'h4C4B40
`define RSW_PIN_TAIL_CYCLES 23'h00000C

`endif

//--- rtl/rsw_sync.v
// Purpose: Two-flop synchroniser for a group of level inputs
// Assumes: Each bit is an independent level, no bus coherency needed
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module rsw_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // Constant reset value; pins are resampled right after release
  always @(posedge clk) begin
    if (!reset_n) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule

//--- rtl/rsw_top.v
// Purpose: Reset-source sequencer and 21-bit watchdog with APB registers
// Assumes: All pin inputs asynchronous; core registers reset by core_reset_n
// Notes: reset_n is treated as a genuine power-up
//
// Summary of operation
// - In reset core halts, ports known, SFRs reset; restart at 0x0000.
// - Data memory untouched by reset; only stack pointer reinitialised.
// - Reset loads port latches with all ones; pull-ups always enabled.
// - Supply or software power-on reset drives pin low until timeout ends.
// - After reset internal oscillator default, watchdog max; wait clock stable.
// - Six reset sources: supply, pin, software, comparator, clock loss, watchdog.
// - Power-up holds reset until supply good, then pin low for timeout.
// - Monitor-enable input high enables supply monitor; tied on small parts.
// - Power-on exit sets bit 1 flag; other resets clear it.
// - Writing one to power-on flag forces full power-on reset.
// - Supply drop with monitor on drives pin low and resets.
// - External low pin resets; held 12 cycles after release; sets bit 0.
// - Enabled clock-loss detector resets, sets bit 2, pin untouched.
// - Armed comparator low resets; bit 5 reads one while armed and after its reset.
// - Watchdog is 21-bit system-clock counter; overflow resets, pin untouched.
// - Every reset exit leaves watchdog running with interval all ones.
// - Restart key enables watchdog and clears its count.
// - Disable needs first key then second key within 4 cycles.
// - Lock key blocks disabling until next reset; no restart effect.
// - Timeout is four to three-plus-interval clock periods; reads give interval.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "rsw_consts.vh"
module rsw_top #(
  parameter [22:0] POR_TIMEOUT_CYCLES = `RSW_POR_CYCLES,
  parameter MONITOR_PIN_PRESENT = 1
) (
  input wire clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rst_pin_in,
  output wire rst_pin_out,
  output wire rst_pin_oe,
  input wire supply_ok,
  input wire supply_monitor_enable_pin,
  input wire clock_missing,
  input wire comparator_low,
  input wire clock_stable,
  output wire core_reset_n,
  output wire [15:0] core_start_addr,
  output wire [7:0] port_latch_value,
  output wire port_latch_load,
  output wire pullup_enable,
  output wire stack_pointer_reinit,
  output wire osc_use_external,
  output wire [1:0] osc_freq_sel,
  output wire watchdog_running
);

  // Sequencer states
  localparam [2:0] S_RUN = 3'h0;
  localparam [2:0] S_SUPPLY = 3'h1;
  localparam [2:0] S_TIMEOUT = 3'h2;
  localparam [2:0] S_PIN = 3'h3;
  localparam [2:0] S_TAIL = 3'h4;

  // Reset causes
  localparam [2:0] C_POR = 3'h0;
  localparam [2:0] C_PIN = 3'h1;
  localparam [2:0] C_CLK = 3'h2;
  localparam [2:0] C_CMP = 3'h3;
  localparam [2:0] C_WDT = 3'h4;

  localparam [22:0] POR_LAST = POR_TIMEOUT_CYCLES - 23'h000001;
  localparam [22:0] TAIL_LAST = `RSW_PIN_TAIL_CYCLES - 23'h000001;

  wire [5:0] sync_q;
  wire pin_low;
  wire mon_en;
  wire supply_fail;
  wire clk_missing_s;
  wire cmp_low_s;
  wire clk_stable_s;
  wire in_run;
  wire apb_wr;
  wire sel_src;
  wire sel_wdt;
  wire sel_osc;
  wire mapped;
  wire src_wr;
  wire wdt_wr;
  wire osc_wr;
  wire sw_por;
  wire clk_trip;
  wire cmp_trip;
  wire wdt_hit;
  wire [4:0] wdt_shamt;
  wire [20:0] wdt_last;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [22:0] cnt_reg;
  reg [22:0] cnt_next;
  reg [2:0] cause_reg;
  reg [2:0] cause_next;
  reg [7:0] flags_reg;
  reg arm_reg;
  reg core_reset_n_reg;
  reg pin_oe_reg;
  reg [7:0] osc_reg;
  reg wdt_en_reg;
  reg [20:0] wdt_cnt_reg;
  reg [2:0] wdt_ival_reg;
  reg wdt_lock_reg;
  reg [2:0] wdt_win_reg;
  reg [31:0] prdata_reg;
  reg [31:0] rd_mux;

  // All pins cross in through two flops before anything looks at them
  rsw_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({clock_stable, comparator_low, clock_missing,
        supply_monitor_enable_pin, supply_ok, rst_pin_in}),
    .q(sync_q)
  );

  assign pin_low = ~sync_q[0];
  assign clk_missing_s = sync_q[3];
  assign cmp_low_s = sync_q[4];
  assign clk_stable_s = sync_q[5];

  // Packages without the enable pin keep the monitor on
  assign mon_en = (MONITOR_PIN_PRESENT == 0) | sync_q[2];
  assign supply_fail = mon_en & ~sync_q[1];

  assign in_run = (state_reg == S_RUN);

  // APB decode; zero wait states, error on unmapped offsets
  assign apb_wr = psel & penable & pwrite;
  assign sel_src = (paddr == `RSW_ADDR_SRC);
  assign sel_wdt = (paddr == `RSW_ADDR_WDT);
  assign sel_osc = (paddr == `RSW_ADDR_OSC);
  assign mapped = sel_src | sel_wdt | sel_osc;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Writes only count while the core runs; a halted core issues none
  assign src_wr = apb_wr & sel_src & in_run;
  assign wdt_wr = apb_wr & sel_wdt & in_run;
  assign osc_wr = apb_wr & sel_osc & in_run;

  // Software power-on request
  assign sw_por = src_wr & pwdata[`RSW_SRC_POR_BIT];

  // Clock-loss detector gated by its oscillator-control enable
  assign clk_trip = osc_reg[`RSW_OSC_CLKDET_BIT] & clk_missing_s;

  // Armed comparator with plus input below minus input
  assign cmp_trip = arm_reg & cmp_low_s;

  // Limit is 4^(3+ival) = 2^(6+2*ival) cycles
  assign wdt_shamt = {1'b0, wdt_ival_reg, 1'b0} + `RSW_WDT_BASE_EXP;
  assign wdt_last = (21'h000001 << wdt_shamt) - 21'h000001;
  // Compare at or above, so shrinking the interval mid-count cannot skip the limit
  assign wdt_hit = wdt_en_reg & (wdt_cnt_reg >= wdt_last);

  // Sequencer next state; supply failure preempts everything
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cause_next = cause_reg;
    if (supply_fail) begin
      state_next = S_SUPPLY;
      cause_next = C_POR;
      cnt_next = 23'h000000;
    end else begin
      case (state_reg)
        S_RUN: begin
          if (sw_por) begin
            state_next = S_TIMEOUT;
            cause_next = C_POR;
            cnt_next = 23'h000000;
          end else if (pin_low) begin
            state_next = S_PIN;
            cause_next = C_PIN;
          end else if (clk_trip) begin
            state_next = S_TAIL;
            cause_next = C_CLK;
            cnt_next = 23'h000000;
          end else if (cmp_trip) begin
            state_next = S_TAIL;
            cause_next = C_CMP;
            cnt_next = 23'h000000;
          end else if (wdt_hit) begin
            state_next = S_TAIL;
            cause_next = C_WDT;
            cnt_next = 23'h000000;
          end
        end
        S_SUPPLY: begin
          // Supply is good or unmonitored here, otherwise the preempt branch is taken
          state_next = S_TIMEOUT;
          cnt_next = 23'h000000;
        end
        S_TIMEOUT: begin
          if (cnt_reg == POR_LAST) begin
            state_next = S_TAIL;
            cnt_next = 23'h000000;
          end else begin
            cnt_next = cnt_reg + 23'h000001;
          end
        end
        S_PIN: begin
          if (!pin_low) begin
            state_next = S_TAIL;
            cnt_next = 23'h000000;
          end
        end
        S_TAIL: begin
          // Pin still reads low briefly after our own release; a power-on
          // keeps its cause, any other reset becomes a pin reset
          if (pin_low) begin
            cnt_next = 23'h000000;
            if (cause_reg != C_POR) begin
              state_next = S_PIN;
              cause_next = C_PIN;
            end
          end else if (cnt_reg == TAIL_LAST) begin
            if (clk_stable_s) begin
              state_next = S_RUN;
            end
          end else begin
            cnt_next = cnt_reg + 23'h000001;
          end
        end
        default: begin
          state_next = S_SUPPLY;
          cause_next = C_POR;
          cnt_next = 23'h000000;
        end
      endcase
    end
  end

  // One merged reset, released on a clock edge
  always @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= S_SUPPLY;
      cnt_reg <= 23'h000000;
      cause_reg <= C_POR;
      core_reset_n_reg <= 1'b0;
      pin_oe_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cause_reg <= cause_next;
      core_reset_n_reg <= (state_next == S_RUN);
      // Only supply and power-on resets pull the pin
      pin_oe_reg <= (state_next == S_SUPPLY) | (state_next == S_TIMEOUT);
    end
  end

  // Cause flags are written on exit from reset; the comparator arm also by source register writes
  always @(posedge clk) begin
    if (!reset_n) begin
      flags_reg <= 8'h00;
      arm_reg <= 1'b0;
    end else if (state_reg == S_TAIL && state_next == S_RUN) begin
      flags_reg <= 8'h00;
      flags_reg[`RSW_SRC_PIN_BIT] <= (cause_reg == C_PIN);
      flags_reg[`RSW_SRC_POR_BIT] <= (cause_reg == C_POR);
      flags_reg[`RSW_SRC_CLK_BIT] <= (cause_reg == C_CLK);
      arm_reg <= (cause_reg == C_CMP);
    end else if (src_wr) begin
      arm_reg <= pwdata[`RSW_SRC_CMP_BIT];
    end
  end

  // Oscillator control returns to defaults on every reset
  always @(posedge clk) begin
    if (!reset_n || !in_run) begin
      osc_reg <= `RSW_OSC_RESET;
    end else if (osc_wr) begin
      osc_reg <= pwdata[7:0] & `RSW_OSC_WMASK;
    end
  end

  // Watchdog; held at reset values while the core is in reset
  always @(posedge clk) begin
    if (!reset_n || !in_run) begin
      wdt_en_reg <= 1'b1;
      wdt_cnt_reg <= 21'h000000;
      wdt_ival_reg <= `RSW_WDT_IVAL_RESET;
      wdt_lock_reg <= 1'b0;
      wdt_win_reg <= 3'h0;
    end else begin
      if (wdt_en_reg) begin
        wdt_cnt_reg <= wdt_cnt_reg + 21'h000001;
      end
      if (wdt_win_reg != 3'h0) begin
        wdt_win_reg <= wdt_win_reg - 3'h1;
      end
      if (wdt_wr) begin
        // Any other watchdog register write in between breaks the disable pair
        wdt_win_reg <= 3'h0;
        case (pwdata[7:0])
          `RSW_KEY_RESTART: begin
            wdt_en_reg <= 1'b1;
            wdt_cnt_reg <= 21'h000000;
          end
          `RSW_KEY_DIS1: begin
            if (!wdt_lock_reg) begin
              wdt_win_reg <= `RSW_WDT_KEY_WINDOW;
            end
          end
          `RSW_KEY_DIS2: begin
            if (!wdt_lock_reg && wdt_win_reg != 3'h0) begin
              wdt_en_reg <= 1'b0;
            end
          end
          `RSW_KEY_LOCK: begin
            wdt_lock_reg <= 1'b1;
          end
          default: begin
            // Interval writes carry bit 7 clear; others are ignored
            if (!pwdata[7]) begin
              wdt_ival_reg <= pwdata[2:0];
            end
          end
        endcase
      end
    end
  end

  // Read data; bit 5 shows the comparator arm, which is also its flag
  always @* begin
    rd_mux = 32'h00000000;
    if (sel_src) begin
      rd_mux[7:0] = flags_reg;
      rd_mux[`RSW_SRC_CMP_BIT] = arm_reg;
    end else if (sel_wdt) begin
      rd_mux[2:0] = wdt_ival_reg;
    end else if (sel_osc) begin
      rd_mux[7:0] = osc_reg;
    end
  end

  // Captured in the setup cycle so the access phase sees a flop
  always @(posedge clk) begin
    if (!reset_n) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  assign prdata = prdata_reg;

  // Open-drain reset pin: only ever pulls low
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = pin_oe_reg;

  // Core-facing reset; no memory clear exists on purpose
  assign core_reset_n = core_reset_n_reg;
  assign stack_pointer_reinit = ~core_reset_n_reg;
  assign core_start_addr = `RSW_RESET_VECTOR;
  assign port_latch_value = `RSW_PORT_LATCH_RESET;
  assign port_latch_load = ~core_reset_n_reg;
  assign pullup_enable = 1'b1;

  // Oscillator selection straight from its register
  assign osc_use_external = osc_reg[`RSW_OSC_EXT_BIT];
  assign osc_freq_sel = osc_reg[`RSW_OSC_FREQ_MSB:`RSW_OSC_FREQ_LSB];
  assign watchdog_running = wdt_en_reg;

endmodule

//--- bench/rsw_chk_sva.sv
// Purpose: Port-level properties of the reset sequencer
// Assumes: Monitor enable driven to a defined level by the far side
// Notes: Counters measure pin drive and pin high time
`timescale 1ns/1ps
module rsw_chk #(
  parameter [22:0] POR_TIMEOUT_CYCLES = 23'd50
) (
  input wire clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire rst_pin_in,
  input wire rst_pin_oe,
  input wire supply_ok,
  input wire supply_monitor_enable_pin,
  input wire clock_stable,
  input wire core_reset_n,
  input wire [15:0] core_start_addr,
  input wire [7:0] port_latch_value,
  input wire port_latch_load,
  input wire pullup_enable,
  input wire stack_pointer_reinit,
  input wire watchdog_running
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Writes only count once the core runs
  wire wr = psel && penable && pwrite && core_reset_n;
  wire wdt = wr && paddr == 8'h04;
  reg [22:0] oe_cnt;
  reg [4:0] hi_cnt;
  // Saturating high-time count, so long idle spans cannot wrap
  always @(posedge clk) begin
    if (!reset_n) begin
      oe_cnt <= 23'h0;
      hi_cnt <= 5'h0;
    end else begin
      oe_cnt <= rst_pin_oe ? oe_cnt + 23'h1 : 23'h0;
      hi_cnt <= !rst_pin_in ? 5'h0 : hi_cnt + {4'h0, hi_cnt != 5'h1F};
    end
  end
  property p_vec;
    core_start_addr == 16'h0000 && port_latch_value == 8'hFF && pullup_enable;
  endproperty
  a_vec: assert property (p_vec) else $error("start or latch value wrong");
  property p_hold;
    port_latch_load == !core_reset_n && stack_pointer_reinit == !core_reset_n;
  endproperty
  a_hold: assert property (p_hold) else $error("load strobes off");
  property p_oe;
    rst_pin_oe |-> !core_reset_n;
  endproperty
  a_oe: assert property (p_oe) else $error("pin driven while running");
  property p_tmo;
    $fell(rst_pin_oe) |-> oe_cnt >= POR_TIMEOUT_CYCLES;
  endproperty
  a_tmo: assert property (p_tmo) else $error("pin drive too short");
  property p_tail;
    $rose(core_reset_n) |-> hi_cnt >= 5'd12 && clock_stable;
  endproperty
  a_tail: assert property (p_tail) else $error("early reset exit");
  property p_run;
    $rose(core_reset_n) |-> watchdog_running;
  endproperty
  a_run: assert property (p_run) else $error("watchdog idle at exit");
  property p_swpor;
    wr && paddr == 8'h00 && pwdata[1] |-> ##[1:2] (!core_reset_n && rst_pin_oe);
  endproperty
  a_swpor: assert property (p_swpor) else $error("no forced power-on");
  property p_restart;
    wdt && pwdata[7:0] == 8'hA5 |=> watchdog_running;
  endproperty
  a_restart: assert property (p_restart) else $error("restart ignored");
  property p_lock;
    wdt && pwdata[7:0] == 8'hFF |=> $stable(watchdog_running);
  endproperty
  a_lock: assert property (p_lock) else $error("lock changed state");
  property p_supply;
    $fell(supply_ok) && supply_monitor_enable_pin && core_reset_n
      |-> ##[1:6] (rst_pin_oe && !core_reset_n);
  endproperty
  a_supply: assert property (p_supply) else $error("supply drop missed");
  c_pin: cover property ($fell(rst_pin_in) && !rst_pin_oe);
  c_por: cover property ($fell(rst_pin_oe));
  c_quiet: cover property ($fell(core_reset_n) && !rst_pin_oe);
endmodule

bind rsw_top rsw_chk #(.POR_TIMEOUT_CYCLES(POR_TIMEOUT_CYCLES)) i_rsw_chk (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rst_pin_in(rst_pin_in),
  .rst_pin_oe(rst_pin_oe), .supply_ok(supply_ok),
  .supply_monitor_enable_pin(supply_monitor_enable_pin), .clock_stable(clock_stable),
  .core_reset_n(core_reset_n), .core_start_addr(core_start_addr),
  .port_latch_value(port_latch_value), .port_latch_load(port_latch_load),
  .pullup_enable(pullup_enable), .stack_pointer_reinit(stack_pointer_reinit),
  .watchdog_running(watchdog_running)
);

//--- bench/rsw_far.sv
// Purpose: Board side of the reset pin and supply monitor enable
// Assumes: Pin has a pull-up; either side may pull it low
// Notes: Pin reads high when nobody pulls
`timescale 1ns/1ps
module rsw_far (
  input wire pin_oe,
  input wire pin_out,
  input wire ext_low,
  input wire mon_on,
  output wire pin,
  output wire mon_en
);
  // Pull-up wins unless the device drives or the board pulls low
  assign pin = (pin_oe ? pin_out : 1'b1) && !ext_low;
  // Board drives the enable to a defined level, never floating
  assign mon_en = mon_on;
endmodule

//--- bench/tb_top.sv
// Purpose: Directed bench for reset sources and watchdog
// Assumes: Short power-on timeout parameter
// Notes: Reset and watchdog outputs are sampled on the falling edge; APB read data on the rising edge
`timescale 1ns/1ps
module tb_top;
  localparam [22:0] POR = 23'd50;
  reg clk = 0;
  reg reset_n = 0;
  reg psel = 0;
  reg penable = 0;
  reg pwrite = 0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [31:0] rd;
  reg se;
  reg ext_low = 0;
  reg mon_on = 1;
  reg supply_ok = 1;
  reg clock_missing = 0;
  reg comparator_low = 0;
  reg clock_stable = 1;
  reg oe_seen = 0;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int f;
  int r;
  wire [31:0] prdata;
  wire [15:0] start;
  wire [7:0] latch;
  wire [1:0] freq;
  wire pready, pslverr, pin, mon_en, pin_oe, core_reset_n, ext, run;
  wire pin_out;
  rsw_top #(.POR_TIMEOUT_CYCLES(POR), .MONITOR_PIN_PRESENT(1)) i_rsw_top (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rst_pin_in(pin), .rst_pin_out(pin_out), .rst_pin_oe(pin_oe),
    .supply_ok(supply_ok), .supply_monitor_enable_pin(mon_en),
    .clock_missing(clock_missing), .comparator_low(comparator_low),
    .clock_stable(clock_stable), .core_reset_n(core_reset_n),
    .core_start_addr(start), .port_latch_value(latch), .port_latch_load(),
    .pullup_enable(), .stack_pointer_reinit(), .osc_use_external(ext),
    .osc_freq_sel(freq), .watchdog_running(run)
  );
  rsw_far i_rsw_far (.pin_oe(pin_oe), .pin_out(pin_out), .ext_low(ext_low),
    .mon_on(mon_on), .pin(pin), .mon_en(mon_en));
  always #10 clk = ~clk;
  // Cycle ceiling and sticky record of any pin drive
  always @(posedge clk) begin
    cyc++;
    if (pin_oe === 1'b1)
      oe_seen = 1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer; holds everything until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  task rn(input logic e);
    @(negedge clk);
    chk("wdt_run", {31'h0, run}, {31'h0, e});
  endtask
  // Cycles to reset entry in f, reset length in r
  task wx;
    f = 0;
    while (core_reset_n !== 1'b0 && f < 400) begin
      @(negedge clk);
      f++;
    end
    r = 0;
    while (core_reset_n !== 1'b1 && r < 400) begin
      @(negedge clk);
      r++;
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1;
    wx;
    rc("cause", 8'h00, 32'h2);
    rc("wdt", 8'h04, 32'h7);
    rc("osc", 8'h08, 32'h0);
    chk("osc_out", {29'h0, ext, freq}, 32'h0);
    chk("vec", {16'h0, start}, 32'h0);
    chk("latch", {24'h0, latch}, 32'hFF);
    chk("oe", {31'h0, oe_seen}, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk("slverr", {31'h0, se}, 32'h1);
    $display("test power_up done");
    apb(1'b1, 8'h04, 32'hDE);
    apb(1'b1, 8'h04, 32'hAD);
    rn(1'b0);
    apb(1'b1, 8'h04, 32'hA5);
    rn(1'b1);
    apb(1'b1, 8'h04, 32'hDE);
    repeat (4) @(posedge clk);
    apb(1'b1, 8'h04, 32'hAD);
    rn(1'b1);
    apb(1'b1, 8'h04, 32'hFF);
    rn(1'b1);
    apb(1'b1, 8'h04, 32'hDE);
    apb(1'b1, 8'h04, 32'hAD);
    rn(1'b1);
    apb(1'b1, 8'h04, 32'h03);
    rc("wdt", 8'h04, 32'h3);
    apb(1'b1, 8'h04, 32'hA5);
    apb(1'b1, 8'h04, 32'h00);
    apb(1'b1, 8'h04, 32'hA5);
    oe_seen = 0;
    wx;
    chk("wdt_time", {31'h0, f >= 63 && f <= 66}, 32'h1);
    chk("oe", {31'h0, oe_seen}, 32'h0);
    rc("cause", 8'h00, 32'h0);
    rc("wdt", 8'h04, 32'h7);
    apb(1'b1, 8'h04, 32'hDE);
    apb(1'b1, 8'h04, 32'hAD);
    rn(1'b0);
    $display("test watchdog done");
    @(posedge clk);
    ext_low <= 1;
    repeat (6) @(posedge clk);
    ext_low <= 0;
    wx;
    chk("pin_tail", {31'h0, r >= 12 && r <= 17}, 32'h1);
    rc("cause", 8'h00, 32'h1);
    apb(1'b1, 8'h08, 32'h8B);
    rc("osc", 8'h08, 32'h8B);
    oe_seen = 0;
    clock_missing <= 1;
    clock_stable <= 0;
    repeat (5) @(posedge clk);
    clock_missing <= 0;
    repeat (30) @(posedge clk);
    clock_stable <= 1;
    @(negedge clk);
    chk("stable_wait", {31'h0, core_reset_n}, 32'h0);
    wx;
    chk("oe", {31'h0, oe_seen}, 32'h0);
    rc("cause", 8'h00, 32'h4);
    rc("osc", 8'h08, 32'h0);
    $display("test pin_clock done");
    comparator_low <= 1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("unarmed", {31'h0, core_reset_n}, 32'h1);
    @(posedge clk);
    comparator_low <= 0;
    apb(1'b1, 8'h00, 32'h20);
    rc("cause", 8'h00, 32'h24);
    comparator_low <= 1;
    repeat (5) @(posedge clk);
    comparator_low <= 0;
    wx;
    chk("oe", {31'h0, oe_seen}, 32'h0);
    rc("cause", 8'h00, 32'h20);
    apb(1'b1, 8'h00, 32'h02);
    wx;
    chk("oe", {31'h0, oe_seen}, 32'h1);
    chk("por_len", {31'h0, r >= 62}, 32'h1);
    rc("cause", 8'h00, 32'h2);
    mon_on <= 0;
    repeat (3) @(posedge clk);
    supply_ok <= 0;
    repeat (5) @(posedge clk);
    supply_ok <= 1;
    repeat (3) @(posedge clk);
    mon_on <= 1;
    @(negedge clk);
    chk("mon_off", {31'h0, core_reset_n}, 32'h1);
    @(posedge clk);
    oe_seen = 0;
    supply_ok <= 0;
    repeat (5) @(posedge clk);
    supply_ok <= 1;
    wx;
    chk("oe", {31'h0, oe_seen}, 32'h1);
    rc("cause", 8'h00, 32'h2);
    $display("test sources done");
    conclude();
  end
endmodule
